// file: logic/sdpci_pkg.sv
// Package: constants and types shared by both ends of the SDRAM pin interface
package sdpci_pkg;
    localparam int DQ_W      = 16;
    localparam int ADDR_W    = 12;
    localparam int BA_W      = 2;
    localparam int NBANK     = 4;
    localparam int COL_W     = 9;
    localparam int DEPTH     = 512;
    localparam int AP_BIT    = 10;
    localparam int DQM_LAT   = 2;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_W    = DQ_W + 2;

    // Command strobes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP   = 4'h7;
    localparam logic [3:0] CMD_ACT   = 4'h3;
    localparam logic [3:0] CMD_READ  = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_BST   = 4'h6;
    localparam logic [3:0] CMD_PRE   = 4'h2;
    localparam logic [3:0] CMD_REF   = 4'h1;
    localparam logic [3:0] CMD_LMR   = 4'h0;
    localparam logic [3:0] CMD_DESEL = 4'h8;

    // Mode register fields
    localparam int MR_BL_LSB  = 0;
    localparam int MR_CL_LSB  = 4;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [ADDR_W-1:0] MODE_RST = 12'h020;
    localparam logic [COL_W:0] FULL_PAGE = 10'h200;

    typedef enum logic [1:0] {SDPCI_CMD_OP_NONE, SDPCI_CMD_OP_RD, SDPCI_CMD_OP_WR} sdpci_op_t;
endpackage : sdpci_pkg

// file: logic/sdpci_if.sv
// Interface: SDRAM command, address and data pins
`timescale 1ns/10ps
interface sdpci_if;
    import sdpci_pkg::*;
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
    logic [1:0]        dqm;
    logic [DQ_W-1:0]   dq_ctl_o;
    logic [DQ_W-1:0]   dq_mem_o;
    logic [DQ_W-1:0]   dq_ctl_oe_n;
    logic [DQ_W-1:0]   dq_mem_oe_n;

    modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctl_o, dq_ctl_oe_n,
                 input dq_mem_o, dq_mem_oe_n);
    modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctl_o, dq_ctl_oe_n,
                 output dq_mem_o, dq_mem_oe_n);
endinterface : sdpci_if

// file: logic/sdpci_fifo.sv
// FIFO with valid/ready on both sides
`timescale 1ns/10ps
module sdpci_fifo #(
    parameter int W = 18,
    parameter int D = 4
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;
    assign in_ready  = cnt_q != (AW+1)'(D);
    assign out_valid = cnt_q != '0;
    assign out_data  = mem_q[rp_q];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= AW'((wp_q + 1'b1) % D);
            if (pop) rp_q <= AW'((rp_q + 1'b1) % D);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge sys_clk) begin
        if (push) mem_q[wp_q] <= in_data;
    end
endmodule : sdpci_fifo

// file: logic/sdpci_mem.sv
// Memory end: command decode, banks, bursts, masks and CKE power states
// Overview of operation
// [RULE1] All inputs sampled on rising sys_clk edge
// [RULE2] Burst counter and output register advance per edge
// [RULE3] CKE low picks power-down, refresh or suspend
// [RULE4] CKE acts asynchronously while powered down; the exit here samples pins.cke on the rising sys_clk edge
// [RULE5] Input buffers disabled in power-down states
// [RULE6] Controller may tie CKE high
// [RULE7] Commands ignored while chip select high
// [RULE8] Bursts and DQM continue under chip select high
// [RULE9] Four strobes on one edge form command
// [RULE10] Masked write data is not stored
// [RULE11] Read mask gives high-Z two cycles later
// [RULE12] Low mask bytes 7:0, high 15:8
// [RULE13] Two bank bits select one of four
// [RULE14] ACTIVE carries the row address
// [RULE15] Column taken from low address bits
// [RULE16] Address bit 10 selects auto precharge
// [RULE17] PRECHARGE bit 10 selects all banks
// [RULE18] Mode register load takes address op-code
// [RULE19] Burst length 1,2,4,8 or full page
// [RULE20] Row must be opened before access
// [RULE21] Controller idles with no-operation commands
`timescale 1ns/10ps
module sdpci_mem (
    // Clock
    input  wire logic      sys_clk,
    // Pins
    sdpci_if.mem           pins,
    // Status
    output sdpci_pkg::sdpci_op_t  burst_op,
    output logic [1:0]     pwr_state
);
    import sdpci_pkg::*;

    // ************************************************************
    // Input registers
    // ************************************************************
    // No reset pin: state settles from the first commands seen.
    logic [3:0]        cmd_q;
    logic [BA_W-1:0]   ba_q;
    logic [ADDR_W-1:0] addr_q;
    logic [1:0]        dqm_q;
    logic [DQ_W-1:0]   din_q;
    logic              cke_q = 1'b1;
    logic              sleep_q = 1'b0;
    wire               in_en = !sleep_q; // [RULE5]

    always_ff @(posedge sys_clk) begin
        if (in_en) begin // [RULE1] [RULE5]
            cmd_q  <= {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n}; // [RULE9]
            ba_q   <= pins.ba;
            addr_q <= pins.addr;
            dqm_q  <= pins.dqm;
            din_q  <= pins.dq_ctl_o;
        end
        cke_q <= pins.cke;
    end

    // ************************************************************
    // Command decode
    // ************************************************************
    wire       run      = cke_q && !sleep_q; // [RULE3]
    wire       sel      = !cmd_q[3]; // [RULE7]
    wire [2:0] op       = cmd_q[2:0];
    wire       is_act   = run && sel && op == CMD_ACT[2:0];
    wire       is_rd    = run && sel && op == CMD_READ[2:0];
    wire       is_wr    = run && sel && op == CMD_WRITE[2:0];
    wire       is_bst   = run && sel && op == CMD_BST[2:0];
    wire       is_pre   = run && sel && op == CMD_PRE[2:0];
    wire       is_ref   = sel && op == CMD_REF[2:0];
    wire       is_lmr   = run && sel && op == CMD_LMR[2:0];
    wire       ap_flag  = addr_q[AP_BIT]; // [RULE16] [RULE17]

    logic [ADDR_W-1:0] mode_q = MODE_RST;
    logic [NBANK-1:0]  open_q = '0;
    logic [ADDR_W-1:0] row_q [NBANK];
    wire  [2:0]        bl_code = mode_q[MR_BL_LSB +: 3];
    wire  [COL_W:0]    bl_len  = (bl_code == BL_FULL) ? FULL_PAGE : // [RULE19]
                                 (COL_W+1)'(1) << bl_code[1:0];
    wire               all_idle = open_q == '0;

    // ************************************************************
    // Power states
    // ************************************************************
    typedef enum logic [1:0] {PS_RUN, PS_PDOWN, PS_SREF, PS_SUSP} sdpci_ps_t;
    sdpci_ps_t ps_q = PS_RUN;
    assign pwr_state = ps_q;

    // Exit from sleep is taken straight from the pin: buffers are off.
    always_ff @(posedge sys_clk) begin
        unique case (ps_q)
            PS_RUN: begin
                if (!pins.cke && is_ref && all_idle) begin
                    ps_q    <= PS_SREF; // [RULE3]
                    sleep_q <= 1'b1;
                end else if (!pins.cke && burst_op != SDPCI_CMD_OP_NONE) begin
                    ps_q <= PS_SUSP; // [RULE3]
                end else if (!pins.cke) begin
                    ps_q    <= PS_PDOWN; // [RULE3]
                    sleep_q <= 1'b1;
                end
            end
            PS_PDOWN, PS_SREF: begin
                if (pins.cke) begin // [RULE4]
                    ps_q    <= PS_RUN;
                    sleep_q <= 1'b0;
                end
            end
            PS_SUSP: begin
                if (pins.cke) ps_q <= PS_RUN;
            end
        endcase
    end

    // ************************************************************
    // Banks, mode register, bursts
    // ************************************************************
    logic [DQ_W-1:0]  arr [NBANK][DEPTH];
    sdpci_op_t        op_q = SDPCI_CMD_OP_NONE;
    logic [BA_W-1:0]  bb_q;
    logic [COL_W-1:0] col_q;
    logic [COL_W:0]   left_q;
    logic             ap_q;
    assign burst_op = op_q;

    wire              adv  = run && op_q != SDPCI_CMD_OP_NONE; // [RULE8]
    wire              last = adv && left_q == (COL_W+1)'(1) && bl_code != BL_FULL;
    wire [COL_W-1:0]  col_in = addr_q[COL_W-1:0]; // [RULE15]

    always_ff @(posedge sys_clk) begin
        if (is_lmr) mode_q <= addr_q; // [RULE18]
        if (is_act) begin
            open_q[ba_q] <= 1'b1; // [RULE13]
            row_q[ba_q]  <= addr_q; // [RULE14]
        end
        if (is_pre) begin
            if (ap_flag) open_q <= '0; // [RULE17]
            else open_q[ba_q] <= 1'b0;
        end
        if ((is_rd || is_wr) && open_q[ba_q]) begin // [RULE20]
            op_q   <= is_rd ? SDPCI_CMD_OP_RD : SDPCI_CMD_OP_WR;
            bb_q   <= ba_q;
            col_q  <= col_in;
            left_q <= bl_len;
            ap_q   <= ap_flag; // [RULE16]
        end else if (is_bst || last) begin
            op_q <= SDPCI_CMD_OP_NONE;
            if (ap_q && last) open_q[bb_q] <= 1'b0; // [RULE16]
        end else if (adv) begin
            col_q  <= col_q + 1'b1; // [RULE2]
            left_q <= left_q - 1'b1;
        end
    end

    // ************************************************************
    // Data path
    // ************************************************************
    wire wr_now = adv && op_q == SDPCI_CMD_OP_WR;
    wire rd_now = adv && op_q == SDPCI_CMD_OP_RD;
    // First beat arrives with the command, one stage before the burst runs
    logic [DQ_W-1:0] din_d_q;
    logic [1:0]      wmask_d_q;
    always_ff @(posedge sys_clk) begin
        din_d_q   <= din_q;
        wmask_d_q <= dqm_q;
        if (wr_now && !wmask_d_q[0]) arr[bb_q][col_q][7:0]  <= din_d_q[7:0]; // [RULE10] [RULE12]
        if (wr_now && !wmask_d_q[1]) arr[bb_q][col_q][15:8] <= din_d_q[15:8]; // [RULE10] [RULE12]
    end

    // Mask pipeline: dqm seen at edge n hides the bus after edge n+2.
    logic [1:0]      mask_d1_q = '0;
    logic [1:0]      mask_d2_q = '0;
    logic            rd_d1_q = 1'b0;
    logic [DQ_W-1:0] dout_q;
    always_ff @(posedge sys_clk) begin
        mask_d1_q <= dqm_q;
        mask_d2_q <= mask_d1_q; // [RULE11]
        rd_d1_q   <= rd_now;
        if (rd_now) dout_q <= arr[bb_q][col_q]; // [RULE2]
    end
    wire hide_lo = !rd_d1_q || mask_d2_q[0]; // [RULE11] [RULE12]
    wire hide_hi = !rd_d1_q || mask_d2_q[1];
    assign pins.dq_mem_o    = dout_q;
    assign pins.dq_mem_oe_n = {{8{hide_hi}}, {8{hide_lo}}};
endmodule : sdpci_mem

// file: logic/sdpci_ctl.sv
// Controller end: issues commands from a request FIFO and returns read data
`timescale 1ns/10ps
module sdpci_ctl (
    // Clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    // Request: {cmd[3:0], ba, addr, dqm, wdata} pushed into FIFO
    input  wire logic                         req_valid,
    output logic                              req_ready,
    input  wire logic [3:0]                   req_cmd,
    input  wire logic [sdpci_pkg::BA_W-1:0]   req_ba,
    input  wire logic [sdpci_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [1:0]                   req_dqm,
    input  wire logic [sdpci_pkg::DQ_W-1:0]   req_wdata,
    input  wire logic                         cke_req,
    // Read data
    output logic [sdpci_pkg::DQ_W-1:0]        rd_data,
    output logic [1:0]                        rd_valid,
    // Pins
    sdpci_if.ctl                              pins
);
    import sdpci_pkg::*;
    localparam int RW = 4 + BA_W + ADDR_W + 2 + DQ_W;

    logic          f_valid;
    logic [RW-1:0] f_data;
    wire           take = f_valid && !rst;
    // Only write and data-beat entries drive the bus, so read returns collide with any NOP entry queued during a read burst
    wire           beat = f_data[RW-1 -: 4] == CMD_WRITE || f_data[RW-1 -: 4] == CMD_NOP;
    sdpci_fifo #(.W(RW), .D(FIFO_DEPTH)) u_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (req_valid),
        .in_ready  (req_ready),
        .in_data   ({req_cmd, req_ba, req_addr, req_dqm, req_wdata}),
        .out_valid (f_valid),
        .out_ready (cke_req),
        .out_data  (f_data)
    );

    // ************************************************************
    // Pin drive
    // ************************************************************
    logic [3:0]        cmd_q;
    logic [BA_W-1:0]   ba_q;
    logic [ADDR_W-1:0] addr_q;
    logic [1:0]        dqm_q;
    logic [DQ_W-1:0]   wd_q;
    logic              wd_en_q;
    logic              cke_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmd_q   <= CMD_NOP;
            ba_q    <= '0;
            addr_q  <= '0;
            dqm_q   <= 2'h3;
            wd_q    <= '0;
            wd_en_q <= 1'b0;
            cke_q   <= 1'b1;
        end else begin
            cke_q   <= cke_req;
            // Idle cycles send no-operation
            cmd_q   <= (take && cke_req) ? f_data[RW-1 -: 4] : CMD_NOP; // [RULE21] [RULE9]
            ba_q    <= f_data[RW-5 -: BA_W];
            addr_q  <= f_data[RW-5-BA_W -: ADDR_W];
            dqm_q   <= take ? f_data[DQ_W+1 -: 2] : 2'h0;
            wd_q    <= f_data[DQ_W-1:0];
            wd_en_q <= take && cke_req && beat;
        end
    end
    assign pins.cke         = cke_q; // [RULE6]
    assign {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = cmd_q;
    assign pins.ba          = ba_q;
    assign pins.addr        = addr_q;
    assign pins.dqm         = dqm_q;
    assign pins.dq_ctl_o    = wd_q;
    assign pins.dq_ctl_oe_n = {DQ_W{!wd_en_q}};

    // ************************************************************
    // Read capture, two flops on the pin
    // ************************************************************
    logic [DQ_W-1:0] s1_q;
    logic [DQ_W-1:0] s2_q;
    logic [1:0]      v1_q;
    logic [1:0]      v2_q;
    wire  [1:0]      lane_on = {!pins.dq_mem_oe_n[8], !pins.dq_mem_oe_n[0]};
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            v1_q <= '0;
            v2_q <= '0;
        end else begin
            s1_q <= pins.dq_mem_o;
            s2_q <= s1_q;
            v1_q <= lane_on;
            v2_q <= v1_q;
        end
    end
    assign rd_data  = s2_q;
    assign rd_valid = v2_q;
endmodule : sdpci_ctl

// file: verification/sdpci_sva.sv
// Checker: pin-level timing of the SDRAM command and data interface
`timescale 1ns/10ps
module sdpci_sva
    import sdpci_pkg::*;
(
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rst,
    // Command pins
    input wire logic                  cke,
    input wire logic                  cs_n,
    input wire logic                  ras_n,
    input wire logic                  cas_n,
    input wire logic                  we_n,
    input wire logic [1:0]            dqm,
    // Data pins
    input wire logic [sdpci_pkg::DQ_W-1:0] dq_mem_o,
    input wire logic [sdpci_pkg::DQ_W-1:0] dq_ctl_oe_n,
    input wire logic [sdpci_pkg::DQ_W-1:0] dq_mem_oe_n
);
    import sdpci_pkg::*;
    wire logic [3:0] cmd_w = {cs_n, ras_n, cas_n, we_n};
    logic [2:0]      rd_age_q;
    logic [2:0]      rd_age_d;
    // Saturating age of the last selected READ
    assign rd_age_d = (cmd_w == CMD_READ && cke) ? 3'h0 : (rd_age_q == 3'h7) ? rd_age_q : rd_age_q + 3'h1;
    always_ff @(posedge sys_clk) begin
        rd_age_q <= rst ? 3'h7 : rd_age_d;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ****************************************
    // Assertions
    // ****************************************
    a_reset_idle_pins: assert property (disable iff (1'b0) rst |=> cmd_w == CMD_NOP && cke && dqm == 2'h3
        && dq_ctl_oe_n == '1) else $error("pins not idle after reset");
    a_rdmask_low_hiz: assert property (dqm[0] && !dq_mem_oe_n[0] |-> ##3 dq_mem_oe_n[7:0] == 8'hFF)
        else $error("low lane not released after mask");
    a_rdmask_high_hiz: assert property (dqm[1] && !dq_mem_oe_n[15] |-> ##3 dq_mem_oe_n[15:8] == 8'hFF)
        else $error("high lane not released after mask");
    a_drive_has_read: assert property ($fell(dq_mem_oe_n[15]) && !$past(dqm[1], 2) && !$past(dqm[1], 3)
        |-> rd_age_q <= 3'h4) else $error("memory drove data without a selected read");
    a_no_bus_fight: assert property ((dq_ctl_oe_n | dq_mem_oe_n) == '1)
        else $error("both ends drive the data bus");
    a_lane_whole: assert property (dq_mem_oe_n[7:0] inside {8'h00, 8'hFF}
        && dq_mem_oe_n[15:8] inside {8'h00, 8'hFF}) else $error("lane enable split");
    a_cke_low_frozen: assert property (!cke [*3] |-> $stable(dq_mem_oe_n)
        && $stable(dq_mem_o | dq_mem_oe_n)) else $error("data pins moved with clock disabled");
    a_write_drives: assert property (cmd_w == CMD_WRITE && dqm == 2'h0 |-> dq_ctl_oe_n == '0)
        else $error("write data not driven with write");
endmodule : sdpci_sva

// file: verification/tb.sv
// Testbench: controller and memory ends joined through the pin interface
`timescale 1ns/10ps
module tb;
    import sdpci_pkg::*;
    logic        sys_clk;
    logic        rst;
    logic        req_valid;
    logic        req_ready;
    logic [3:0]  req_cmd;
    logic [1:0]  req_ba;
    logic [11:0] req_addr;
    logic [1:0]  req_dqm;
    logic [15:0] req_wdata;
    logic        cke_req;
    logic [15:0] rd_data;
    logic [1:0]  rd_valid;
    sdpci_op_t   burst_op;
    logic [1:0]  pwr_state;
    logic [15:0] got[4];
    logic [1:0]  gotv[4];
    logic [15:0] lm;
    int          n_errors;
    int          total_checks;
    sdpci_if pins();
    sdpci_ctl sdpci_ctl_inst (.sys_clk, .rst, .req_valid, .req_ready, .req_cmd, .req_ba, .req_addr,
        .req_dqm, .req_wdata, .cke_req, .rd_data, .rd_valid, .pins(pins.ctl));
    sdpci_mem sdpci_mem_inst (.sys_clk, .pins(pins.mem), .burst_op, .pwr_state);
    sdpci_sva sdpci_sva_inst (.sys_clk, .rst, .cke(pins.cke), .cs_n(pins.cs_n), .ras_n(pins.ras_n),
        .cas_n(pins.cas_n), .we_n(pins.we_n), .dqm(pins.dqm), .dq_mem_o(pins.dq_mem_o),
        .dq_ctl_oe_n(pins.dq_ctl_oe_n), .dq_mem_oe_n(pins.dq_mem_oe_n));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    // Leaves valid high so back-to-back pushes never toggle it
    task automatic push(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a, input logic [1:0] m,
                        input logic [15:0] d);
        int k;
        {req_cmd, req_ba, req_addr, req_dqm, req_wdata} = {c, b, a, m, d};
        req_valid = 1'b1;
        for (k = 0; k < 40 && req_ready !== 1'b1; k++) @(posedge sys_clk) #1;
        if (k == 40) begin
            n_errors++;
            finish_test();
        end
        @(posedge sys_clk) #1;
    endtask : push
    task automatic burst_wr(input logic [3:0] c, input logic [15:0] base, input logic [1:0] m2);
        push(c, 2'h1, 12'h0A4, 2'h0, base);
        for (int i = 1; i < 4; i++) push(CMD_NOP, 2'h1, 12'h0A4, (i == 2) ? m2 : 2'h0, base + 16'(i));
    endtask : burst_wr
    // Beats after the read are deselects: the burst must run on
    task automatic burst_rd(input logic [11:0] a, input logic [1:0] m3);
        int k;
        fork
            begin
                push(CMD_READ, 2'h1, a, 2'h0, 16'h0000);
                for (int i = 1; i < 4; i++) push(CMD_DESEL, 2'h1, a, (i == 3) ? m3 : 2'h0, 16'h0000);
                req_valid = 1'b0;
            end
            begin
                for (k = 0; k < 30 && rd_valid === 2'h0; k++) @(posedge sys_clk) #1;
                for (int i = 0; i < 4; i++) begin
                    got[i] = rd_data;
                    gotv[i] = rd_valid;
                    @(posedge sys_clk) #1;
                end
            end
        join
    endtask : burst_rd
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        int k;
        {req_valid, req_ba, req_addr, req_dqm, req_wdata} = '0;
        req_cmd = CMD_NOP;
        rst = 1'b1;
        cke_req = 1'b1;
        repeat (5) @(posedge sys_clk);
        #1 rst = 1'b0;
        push(CMD_LMR, 2'h0, 12'h022, 2'h0, 16'h0000);
        push(CMD_ACT, 2'h1, 12'h123, 2'h0, 16'h0000);
        burst_wr(CMD_WRITE, 16'h1100, 2'h0);
        burst_wr(CMD_WRITE, 16'h2200, 2'h2);
        burst_wr(4'hC, 16'h3300, 2'h0);
        burst_rd(12'hAA4, 2'h1);
        for (int i = 0; i < 4; i++) begin
            lm = (i == 3) ? 16'hFF00 : 16'hFFFF;
            check("rd_valid", gotv[i], (i == 3) ? 2'h2 : 2'h3);
            check("rd_data", got[i] & lm, ((i == 2) ? 16'h1102 : 16'h2200 + 16'(i)) & lm);
        end
        burst_rd(12'h4A4, 2'h3);
        check("rd_data", got[0], 16'h2200);
        check("rd_valid", gotv[3], 2'h0);
        burst_rd(12'h0A4, 2'h0);
        check("rd_valid", gotv[0], 2'h0);
        push(CMD_ACT, 2'h1, 12'h123, 2'h0, 16'h0000);
        push(CMD_ACT, 2'h2, 12'h045, 2'h0, 16'h0000);
        push(CMD_PRE, 2'h2, 12'h000, 2'h0, 16'h0000);
        burst_rd(12'h0A4, 2'h0);
        check("rd_data", got[0], 16'h2200);
        push(CMD_PRE, 2'h0, 12'h400, 2'h0, 16'h0000);
        burst_rd(12'h0A4, 2'h0);
        check("rd_valid", gotv[0], 2'h0);
        cke_req = 1'b0;
        for (k = 0; k < 8 && pwr_state !== 2'h1; k++) @(posedge sys_clk) #1;
        check("pwr_state", pwr_state, 2'h1);
        req_cmd = CMD_NOP;
        req_valid = 1'b1;
        for (k = 0; k < 8 && req_ready === 1'b1; k++) @(posedge sys_clk) #1;
        check("fifo fill", k, FIFO_DEPTH);
        req_valid = 1'b0;
        cke_req = 1'b1;
        for (k = 0; k < 8 && pwr_state !== 2'h0; k++) @(posedge sys_clk) #1;
        check("pwr_state", pwr_state, 2'h0);
        repeat (8) @(posedge sys_clk);
        check("req_ready", req_ready, 1'b1);
        finish_test();
    end
endmodule : tb
